//--- hdl/port_function_mux.sv
// Pin function multiplexer for four 8-bit ports with bus expansion
//
// Functional notes
// - Microprocessor mode forces expansion function B everywhere
// - Microcomputer mode starts all pins as inputs
// - Software picks output, input, function A or B
// - Expansion functions selectable pin by pin
// - Program memory off: frame accesses go external
// - Two select bits jointly choose pin function
// - GPIO: direction bit chooses, value bit drives/reads
`timescale 1ns/1ps
module port_function_mux
    import port_mux_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       mode_mpu,
    input  wire logic       prog_mem_off,
    input  wire reg_req_s   req,
    output logic [7:0]      rdata,
    input  wire port_bits_t pin_in,
    output port_bits_t      pin_out,
    output port_bits_t      pin_oe,
    input  wire exp_drive_s exp_drv,
    output port_bits_t      exp_in,
    output ext_req_s        ext,
    input  wire logic [7:0] ext_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        port_bits_t sel_a;
        port_bits_t sel_b;
        port_bits_t dir;
        port_bits_t val;
        port_bits_t s1;
        port_bits_t s2;
        port_bits_t s3;
        port_bits_t pin;
        port_bits_t out;
        port_bits_t oe;
        logic [7:0] rdata;
        logic       mpu;
        logic       ext_mem;
        logic       strapped;
        ext_req_s   ext;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic pin_fn_e pin_fn(input logic mpu, input logic a,
                                       input logic b);
        if (mpu || b)
            return FN_EXPB;
        else if (a)
            return FN_EXPA;
        else
            return FN_GPIO;
    endfunction : pin_fn

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       hit;
        logic [1:0] port;
        logic [1:0] off;
        pin_fn_e    fn;
        next_st = st;
        hit  = (req.addr & FRAME_MASK) == FRAME_BASE;
        port = req.addr[3:2];
        off  = req.addr[1:0];
        fn   = FN_GPIO;

        // Straps are caught once, on the first edge after release
        if (!st.strapped) begin
            next_st.strapped = 1'b1;
            next_st.mpu      = mode_mpu;
            next_st.ext_mem  = prog_mem_off;
        end

        // Three-stage sync; level accepted once stages 2 and 3 agree
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int p = 0; p < NPORTS; p++) begin
            for (int b = 0; b < NBITS; b++) begin
                if (st.s2[p][b] == st.s3[p][b])
                    next_st.pin[p][b] = st.s3[p][b];
            end
        end

        // Register access or external forwarding
        next_st.ext.req = 1'b0;
        next_st.rdata   = RD_IDLE;
        if (hit && st.ext_mem && (req.wr || req.rd)) begin
            next_st.ext.req   = 1'b1;
            next_st.ext.wr    = req.wr;
            next_st.ext.off   = req.addr[3:0];
            next_st.ext.wdata = req.wdata;
            if (req.rd)
                next_st.rdata = ext_rdata;
        end else if (hit && req.wr) begin
            unique case (off)
                OFF_SEL_A: next_st.sel_a[port] = req.wdata;
                OFF_SEL_B: next_st.sel_b[port] = req.wdata;
                OFF_VALUE: next_st.val[port]   = req.wdata;
                OFF_DIR:   next_st.dir[port]   = req.wdata;
            endcase
        end else if (hit && req.rd) begin
            unique case (off)
                OFF_SEL_A: next_st.rdata = st.sel_a[port];
                OFF_SEL_B: next_st.rdata = st.sel_b[port];
                OFF_DIR:   next_st.rdata = st.dir[port];
                OFF_VALUE: begin
                    // Input pins read the pin, outputs read the latch
                    for (int b = 0; b < NBITS; b++)
                        next_st.rdata[b] = st.dir[port][b] ?
                            st.val[port][b] : st.pin[port][b];
                end
            endcase
        end

        // Per-pin function select; no pin drives before straps land
        for (int p = 0; p < NPORTS; p++) begin
            for (int b = 0; b < NBITS; b++) begin
                fn = pin_fn(st.mpu, st.sel_a[p][b],
                            st.sel_b[p][b]);
                unique case (fn)
                    FN_GPIO: begin
                        next_st.out[p][b] = st.val[p][b];
                        next_st.oe[p][b]  = st.dir[p][b];
                    end
                    FN_EXPA: begin
                        next_st.out[p][b] = exp_drv.out_a[p][b];
                        next_st.oe[p][b]  = exp_drv.oe_a[p][b];
                    end
                    FN_EXPB: begin
                        next_st.out[p][b] = exp_drv.out_b[p][b];
                        next_st.oe[p][b]  = exp_drv.oe_b[p][b];
                    end
                    default: begin
                        next_st.out[p][b] = 1'b0;
                        next_st.oe[p][b]  = 1'b0;
                    end
                endcase
                if (!st.strapped) begin
                    next_st.out[p][b] = 1'b0;
                    next_st.oe[p][b]  = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.sel_a <= {NPORTS{RST_SEL}};
            st.sel_b <= {NPORTS{RST_SEL}};
            st.dir   <= {NPORTS{RST_DIR}};
            st.val   <= {NPORTS{RST_VAL}};
        end else begin
            st <= next_st;
        end
    end

    assign rdata   = st.rdata;
    assign pin_out = st.out;
    assign pin_oe  = st.oe;
    assign exp_in  = st.pin;
    assign ext     = st.ext;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    mpu_force_b_a: assert property (
        $past(st.mpu) && $past(st.strapped)
        |-> pin_oe == $past(exp_drv.oe_b) && pin_out == $past(exp_drv.out_b))
        else $error("Microprocessor mode pins not on function B");

    mcu_start_hiz_a: assert property (
        $rose(st.strapped) && !st.mpu |-> ##1 (pin_oe == '0) [*2])
        else $error("Microcomputer mode pins not high impedance");

    sel_write_a: assert property (
        req.wr && !st.ext_mem && st.strapped && req.addr == FRAME_BASE
        |=> st.sel_a[0] == $past(req.wdata))
        else $error("Function select write not taken");

    per_pin_a: assert property (
        !st.mpu && st.strapped && st.sel_b[1] == 8'h0f && st.sel_a[1] == '0
        |=> pin_oe[1][7:4] == $past(st.dir[1][7:4])
            && pin_oe[1][3:0] == $past(exp_drv.oe_b[1][3:0]))
        else $error("Pin functions of one port not independent");

    ext_frame_a: assert property (
        st.ext_mem && req.wr && (req.addr & FRAME_MASK) == FRAME_BASE
        |=> ext.req && ext.wr && $stable(st.val) && $stable(st.dir))
        else $error("Frame access not forwarded externally");

    fn_a_select_a: assert property (
        !$past(st.mpu) && $past(st.strapped) && $past(st.sel_a[2][3])
        && !$past(st.sel_b[2][3])
        |-> pin_out[2][3] == $past(exp_drv.out_a[2][3])
            && pin_oe[2][3] == $past(exp_drv.oe_a[2][3]))
        else $error("Select pair does not pick function A");

    gpio_read_a: assert property (
        req.rd && !st.ext_mem && req.addr == (FRAME_BASE | 16'h0002)
        && st.dir[0] == 8'hff
        |=> rdata == $past(st.val[0]) ##1 (rdata == '0 || $past(req.rd)))
        else $error("Output value read back wrong");

    exp_ignores_dir_a: assert property (
        $past(st.strapped) && ($past(st.sel_b[3][0]) || $past(st.mpu))
        |-> pin_oe[3][0] == $past(exp_drv.oe_b[3][0]))
        else $error("Direction bit leaks onto expansion pin");

endmodule : port_function_mux

//--- hdl/port_mux_pkg.sv
// Shared constants and carriers for the port function multiplexer
package port_mux_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NPORTS = 4;
    localparam int NBITS  = 8;

    // ------------------------------------------------------------
    // Register frame: four registers per port, port p at p*4
    // ------------------------------------------------------------
    localparam logic [15:0] FRAME_BASE = 16'h1020;
    localparam logic [15:0] FRAME_MASK = 16'hfff0;
    localparam logic [1:0]  OFF_SEL_A  = 2'h0;
    localparam logic [1:0]  OFF_SEL_B  = 2'h1;
    localparam logic [1:0]  OFF_VALUE  = 2'h2;
    localparam logic [1:0]  OFF_DIR    = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SEL  = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'h00;
    localparam logic [7:0] RST_VAL  = 8'h00;
    localparam logic [7:0] RD_IDLE  = 8'h00;

    typedef enum logic [1:0] {
        FN_GPIO = 2'b00,
        FN_EXPA = 2'b01,
        FN_EXPB = 2'b10
    } pin_fn_e;

    typedef logic [NPORTS-1:0][NBITS-1:0] port_bits_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        port_bits_t out_a;
        port_bits_t oe_a;
        port_bits_t out_b;
        port_bits_t oe_b;
    } exp_drive_s;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [3:0]  off;
        logic [7:0]  wdata;
    } ext_req_s;

endpackage : port_mux_pkg

//--- dv/far_side_model.sv
// Far-side model: external bus devices and pin loads
`timescale 1ns/1ps
module far_side_model
    import port_mux_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire port_bits_t pin_out,
    input  wire port_bits_t pin_oe,
    input  wire port_bits_t far_val,
    input  wire ext_req_s   ext,
    input  wire logic [3:0] rd_off,
    output port_bits_t      pin_in,
    output logic [7:0]      ext_rdata
);
    // ------------------------------------------------------------
    // Emulated port frame
    // ------------------------------------------------------------
    logic [7:0] regs [16];

    initial begin
        for (int i = 0; i < 16; i++) regs[i] = 8'h00;
    end

    always @(posedge ref_clk) begin
        if (ext.req && ext.wr) regs[ext.off] <= ext.wdata;
    end

    // Offset comes from the bus itself, read data is needed in-cycle
    assign ext_rdata = regs[rd_off];

    // Device drive wins, else the external load sets the level
    assign pin_in = (pin_out & pin_oe) | (far_val & ~pin_oe);
endmodule : far_side_model

//--- dv/port_function_and_bus_expansion_mux_tb.sv
// Self-checking bench for the port function multiplexer
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module port_function_and_bus_expansion_mux_tb
    import port_mux_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       ref_clk      = 1'b0;
    logic       rst          = 1'b1;
    logic       mode_mpu     = 1'b0;
    logic       prog_mem_off = 1'b0;
    reg_req_s   req          = '0;
    port_bits_t far_val      = 32'h6996c33c;
    exp_drive_s exp_drv      = {32'h11223344, 32'h0f0f0f0f,
                                32'ha5c33c5a, 32'hff00f0ff};
    logic [7:0] rdata;
    logic [7:0] ext_rdata;
    logic [7:0] e_oe;
    logic [7:0] e_out;
    port_bits_t pin_in;
    port_bits_t pin_out;
    port_bits_t pin_oe;
    port_bits_t exp_in;
    ext_req_s   ext;
    int         fails   = 0;
    int         checked = 0;

    port_function_mux dut_u (.ref_clk(ref_clk), .rst(rst),
        .mode_mpu(mode_mpu), .prog_mem_off(prog_mem_off), .req(req),
        .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .exp_drv(exp_drv), .exp_in(exp_in),
        .ext(ext), .ext_rdata(ext_rdata));

    far_side_model far_u (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .far_val(far_val), .ext(ext),
        .rd_off(req.addr[3:0]), .pin_in(pin_in), .ext_rdata(ext_rdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic acc(input logic [15:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask : acc

    task automatic rd_chk(input string n, input logic [15:0] a,
                          input logic [7:0] e);
        acc(a, 8'h00, 1'b0);
        #1;
        `CHK(n, e, rdata)
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    // Straps are taken once, so every mode needs its own reset
    task automatic start(input logic mpu, input logic pmo);
        @(posedge ref_clk);
        rst          <= 1'b1;
        mode_mpu     <= mpu;
        prog_mem_off <= pmo;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : start

    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        #100000;
        fails++;
        finish_test();
    end

    initial begin
        start(1'b0, 1'b0);
        `CHK("oe_idle", 32'h0, pin_oe)
        rd_chk("in_a", 16'h1022, far_val[0]);
        acc(16'h1022, 8'h5a, 1'b1);
        acc(16'h1023, 8'hff, 1'b1);
        settle();
        `CHK("out_a", 8'h5a, pin_out[0])
        `CHK("oe_a", 8'hff, pin_oe[0])
        rd_chk("val_a", 16'h1022, 8'h5a);
        acc(16'h1026, 8'h96, 1'b1);
        acc(16'h1027, 8'hff, 1'b1);
        acc(16'h1024, 8'h0b, 1'b1);
        acc(16'h1025, 8'h0c, 1'b1);
        settle();
        // Bit 3 has both selects set, so function B must win
        e_oe  = (exp_drv.oe_a[1] & 8'h03) | (exp_drv.oe_b[1] & 8'h0c) |
                8'hf0;
        e_out = (exp_drv.out_a[1] & 8'h03) | (exp_drv.out_b[1] & 8'h0c) |
                8'h90;
        `CHK("oe_mix", e_oe, pin_oe[1])
        `CHK("out_mix", e_out, pin_out[1])
        acc(16'h1024, 8'h00, 1'b1);
        acc(16'h1025, 8'h0f, 1'b1);
        acc(16'h1028, 8'h08, 1'b1);
        settle();
        e_oe  = (exp_drv.oe_b[1] & 8'h0f) | 8'hf0;
        e_out = (exp_drv.out_b[1] & 8'h0f) | 8'h90;
        `CHK("oe_split", e_oe, pin_oe[1])
        `CHK("out_split", e_out, pin_out[1])
        `CHK("oe_fn_a", exp_drv.oe_a[2] & 8'h08, pin_oe[2])
        rd_chk("unmapped", 16'h1030, 8'h00);
        $display("test mcu done");

        start(1'b1, 1'b0);
        `CHK("oe_mpu", exp_drv.oe_b, pin_oe)
        `CHK("out_mpu", exp_drv.out_b, pin_out)
        e_out = (exp_drv.out_b[0] & exp_drv.oe_b[0]) |
                (far_val[0] & ~exp_drv.oe_b[0]);
        `CHK("exp_in", e_out, exp_in[0])
        // Selects stay writable but must not move pins off function B
        acc(16'h1020, 8'hff, 1'b1);
        settle();
        `CHK("oe_mpu_sel", exp_drv.oe_b, pin_oe)
        rd_chk("sel_mpu", 16'h1020, 8'hff);
        $display("test mpu done");

        start(1'b0, 1'b1);
        acc(16'h1025, 8'hc3, 1'b1);
        #1;
        `CHK("ext_req", 1'b1, ext.req)
        `CHK("ext_wr", 1'b1, ext.wr)
        `CHK("ext_off", 4'h5, ext.off)
        `CHK("ext_wd", 8'hc3, ext.wdata)
        settle();
        `CHK("oe_ext", 32'h0, pin_oe)
        rd_chk("ext_rd", 16'h1025, 8'hc3);
        `CHK("ext_rd_req", 1'b1, ext.req)
        `CHK("ext_rd_wr", 1'b0, ext.wr)
        $display("test external done");
        finish_test();
    end
endmodule : port_function_and_bus_expansion_mux_tb
